// ### seq_pkg.sv
// package: constants, types and the functional notes of the state sequencer next-state block
// Functional notes
// - the three selectors and the flag register share one address, one shown at a time.
// - view field 00 state1, 01 state2, 10 state3, 11 match flags.
// - state1 selector readable at view 00, writable at view 00 while disarmed.
// - state2 selector readable at view 01, writable at view 01 while disarmed.
// - each selector is a 4-bit field in bits 3..0 choosing the next state.
// - state1 codes 0000/0001/0010: any match to state2, state3, final.
// - state1 codes 0011/0100/0101: only channel 2 to state2, state3, final.
// - state1 codes 0110..1001 pair channels 0,1,2 to state2, state3 or final.
// - state1 codes 1010, 1011 pair channels 1,3; 1100 sends channels 0-2 to state2.
// - reserved codes cause no transition at all.
// - state2 codes 0000/0001/0010: any match to state1, state3, final.
// - state2 codes 0011/0100/0101: only channel 3 to state1, state3, final.
// - state2 codes 0110..1001 pair channels 0,1,2 to state1, state3 or final.
// - state2 codes 1010..1100 pair channels 1,2,3 to state1, state3, final; 1101 sends channels 0,1,3 to final.
// - on simultaneous matches the lowest-numbered channel wins.
// - a match leading to final state beats every other match.
// - pair mapping 00 puts comparator A on channel 0 and B on channel 1.
`default_nettype none
package seq_pkg;
  // register indices; the bus byte address is four times the index
  localparam logic [31:0] ADDR_SHARED = 32'h0000_0027;
  localparam logic [31:0] ADDR_CONTROL = 32'h0000_0020;
  localparam logic [31:0] ADDR_COMPARATOR = 32'h0000_0028;
  localparam int CTRL_ARM_BIT = 7;
  localparam int CTRL_MAP_LO = 2;
  localparam int CTRL_VIEW_LO = 0;
  localparam int CMP_EN_LO = 0;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [1:0] VIEW_STATE1 = 2'h0;
  localparam logic [1:0] VIEW_STATE2 = 2'h1;
  localparam logic [1:0] VIEW_STATE3 = 2'h2;
  localparam logic [1:0] VIEW_FLAGS = 2'h3;
  localparam logic [1:0] MAP_PLAIN = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ONE = 5'h02,
    ST_TWO = 5'h04,
    ST_THREE = 5'h08,
    ST_FINAL = 5'h10
  } seq_state_e;

  // decoded outcome of one selector lookup
  typedef struct packed {
    logic go;
    seq_state_e dest;
  } next_dec_s;

  typedef struct packed {
    logic arm;
    logic [1:0] pair_map;
    logic [1:0] view;
  } ctrl_s;
endpackage : seq_pkg
`default_nettype wire

// ### next_state_decode.sv
// selector-code to next-state decoder for states 1 and 2
`default_nettype none
module next_state_decode
  import seq_pkg::*;
(
  input wire logic in_state2,
  input wire logic [3:0] code,
  input wire logic [3:0] match,
  output logic go,
  output seq_state_e dest
);
  seq_state_e here;
  seq_state_e other;
  logic [3:0] to_other;
  logic [3:0] to_three;
  logic [3:0] to_final;

  // state1 and state2 tables differ only in the single-channel and top codes
  always_comb begin
    other = in_state2 ? ST_ONE : ST_TWO;
    here = in_state2 ? ST_TWO : ST_ONE;
    to_other = 4'h0;
    to_three = 4'h0;
    to_final = 4'h0;
    case (code)
      4'h0: to_other = 4'hF;
      4'h1: to_three = 4'hF;
      4'h2: to_final = 4'hF;
      4'h3: to_other = in_state2 ? 4'h8 : 4'h4;
      4'h4: to_three = in_state2 ? 4'h8 : 4'h4;
      4'h5: to_final = in_state2 ? 4'h8 : 4'h4;
      4'h6: begin
        to_other = 4'h1;
        to_three = 4'h2;
      end
      4'h7: begin
        to_three = 4'h2;
        to_final = 4'h1;
      end
      4'h8: begin
        to_other = 4'h1;
        to_three = 4'h4;
      end
      4'h9: begin
        to_three = 4'h4;
        to_final = 4'h1;
      end
      4'hA: begin
        to_other = 4'h2;
        to_three = 4'h8;
      end
      4'hB: begin
        to_three = 4'h8;
        to_final = 4'h2;
      end
      4'hC: begin
        to_other = in_state2 ? 4'h4 : 4'h7;
        to_final = in_state2 ? 4'h8 : 4'h0;
      end
      4'hD: to_final = in_state2 ? 4'hB : 4'h0;
      default: to_other = 4'h0;
    endcase
    go = 1'b0;
    dest = here;
    // final wins outright, then lowest channel decides
    if ((to_final & match) != 4'h0) begin
      go = 1'b1;
      dest = ST_FINAL;
    end else begin
      for (int i = 3; i >= 0; i--) begin
        if (match[i] && (to_other[i] || to_three[i])) begin
          go = 1'b1;
          dest = to_other[i] ? other : ST_THREE;
        end
      end
    end
  end
endmodule : next_state_decode
`default_nettype wire

// ### match_sync.sv
// two-flop synchroniser for the raw comparator hit lines
`default_nettype none
module match_sync
  import seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] raw,
  output logic [3:0] synced
);
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= 4'h0;
      sync_ff <= 4'h0;
    end else begin
      meta_ff <= raw;
      sync_ff <= meta_ff;
    end
  end
  assign synced = sync_ff;
endmodule : match_sync
`default_nettype wire

// ### seq_next_state.sv
// state sequencer next-state block with its axi4-lite register slave
//
// Added by the designer: the AXI4-Lite slave port.
`default_nettype none
module seq_next_state
  import seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] comp_hit,
  output logic [4:0] seq_state,
  output logic final_reached
);
  ctrl_s ctrl_ff;
  logic [3:0] sel1_ff;
  logic [3:0] sel2_ff;
  logic [3:0] sel3_ff;
  logic [3:0] flags_ff;
  logic [3:0] cmp_en_ff;
  seq_state_e state_ff;
  logic final_ff;
  logic [31:0] awaddr_ff;
  logic aw_have_ff;
  logic [31:0] wdata_ff;
  logic w_have_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic arready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [3:0] hit_sync;
  logic [3:0] match;
  logic do_write;
  logic arm_rise;
  logic dec_go;
  seq_state_e dec_dest;
  logic [3:0] cur_code;

  match_sync match_sync_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw(comp_hit),
    .synced(hit_sync)
  );

  // channel 1 passes only with mapping 00; range modes live in the comparators
  always_comb begin
    match = hit_sync & cmp_en_ff;
    if (ctrl_ff.pair_map != MAP_PLAIN) begin
      match[1] = 1'b0;
    end
  end

  // write handshake: address and data taken in either order
  assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      awready_ff <= 1'b1;
      awaddr_ff <= 32'h0000_0000;
    end else if (s_axi_awvalid && !aw_have_ff) begin
      aw_have_ff <= 1'b1;
      awready_ff <= 1'b0;
      awaddr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_ff <= 1'b0;
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_ff <= 1'b0;
      wready_ff <= 1'b1;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && !w_have_ff) begin
      w_have_ff <= 1'b1;
      wready_ff <= 1'b0;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (do_write) begin
      w_have_ff <= 1'b0;
      wready_ff <= 1'b1;
    end
  end

  // readies kept as flops beside the holding bits, no gate after them
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (awaddr_ff[31:2] == ADDR_CONTROL[29:0] || awaddr_ff[31:2] == ADDR_SHARED[29:0]
                   || awaddr_ff[31:2] == ADDR_COMPARATOR[29:0]) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  assign arm_rise = do_write && awaddr_ff[31:2] == ADDR_CONTROL[29:0] && wstrb_ff[0]
                    && wdata_ff[CTRL_ARM_BIT] && !ctrl_ff.arm;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= '0;
    end else if (do_write && awaddr_ff[31:2] == ADDR_CONTROL[29:0] && wstrb_ff[0]) begin
      ctrl_ff.arm <= wdata_ff[CTRL_ARM_BIT];
      ctrl_ff.pair_map <= wdata_ff[CTRL_MAP_LO +: 2];
      ctrl_ff.view <= wdata_ff[CTRL_VIEW_LO +: 2];
    end
  end

  // comparator enables only change while disarmed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_en_ff <= 4'h0;
    end else if (do_write && awaddr_ff[31:2] == ADDR_COMPARATOR[29:0] && wstrb_ff[0] && !ctrl_ff.arm) begin
      cmp_en_ff <= wdata_ff[CMP_EN_LO +: 4];
    end
  end

  // shared word: only the selected view's selector accepts data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel1_ff <= SEL_RESET;
      sel2_ff <= SEL_RESET;
      sel3_ff <= SEL_RESET;
    end else if (do_write && awaddr_ff[31:2] == ADDR_SHARED[29:0] && wstrb_ff[0] && !ctrl_ff.arm) begin
      case (ctrl_ff.view)
        VIEW_STATE1: sel1_ff <= wdata_ff[3:0];
        VIEW_STATE2: sel2_ff <= wdata_ff[3:0];
        VIEW_STATE3: sel3_ff <= wdata_ff[3:0];
        default: sel3_ff <= sel3_ff;
      endcase
    end
  end

  // flags stick until the next arming write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= 4'h0;
    end else if (arm_rise) begin
      flags_ff <= 4'h0;
    end else if (ctrl_ff.arm) begin
      flags_ff <= flags_ff | match;
    end
  end

  // read side; each register sits in the low bits, the selectors and flags sharing one word by view
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      arready_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      if (s_axi_araddr[31:2] == ADDR_CONTROL[29:0]) begin
        rdata_ff <= {24'h00_0000, ctrl_ff.arm, 3'h0, ctrl_ff.pair_map, ctrl_ff.view};
      end else if (s_axi_araddr[31:2] == ADDR_SHARED[29:0]) begin
        case (ctrl_ff.view)
          VIEW_STATE1: rdata_ff <= {28'h000_0000, sel1_ff};
          VIEW_STATE2: rdata_ff <= {28'h000_0000, sel2_ff};
          VIEW_STATE3: rdata_ff <= {28'h000_0000, sel3_ff};
          default: rdata_ff <= {28'h000_0000, flags_ff};
        endcase
      end else if (s_axi_araddr[31:2] == ADDR_COMPARATOR[29:0]) begin
        rdata_ff <= {28'h000_0000, cmp_en_ff};
      end else begin
        rresp_ff <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  assign cur_code = (state_ff == ST_TWO) ? sel2_ff : sel1_ff;

  next_state_decode next_state_decode_i (
    .in_state2(state_ff == ST_TWO),
    .code(cur_code),
    .match(match),
    .go(dec_go),
    .dest(dec_dest)
  );

  // state 3 onward is handled elsewhere; this block parks there
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
    end else if (!ctrl_ff.arm) begin
      state_ff <= arm_rise ? ST_ONE : ST_IDLE;
    end else begin
      case (state_ff)
        ST_ONE, ST_TWO: state_ff <= dec_go ? dec_dest : state_ff;
        ST_IDLE: state_ff <= ST_IDLE;
        ST_THREE: state_ff <= ST_THREE;
        ST_FINAL: state_ff <= ST_FINAL;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      final_ff <= 1'b0;
    end else begin
      final_ff <= ctrl_ff.arm && state_ff == ST_FINAL;
    end
  end

  assign seq_state = state_ff;
  assign final_reached = final_ff;

  a_disarmed_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_ff.arm && !arm_rise |=> state_ff == ST_IDLE)
    else $error("state moved while disarmed");
  a_final_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_ff.arm && state_ff == ST_ONE && sel1_ff == 4'h7 && match[0] |=> state_ff == ST_FINAL)
    else $error("final match did not win");
  a_low_chan_first: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_ff.arm && state_ff == ST_ONE && sel1_ff == 4'h6 && match[0] && match[1] |=> state_ff == ST_TWO)
    else $error("lower channel lost priority");
  a_reserved_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_ff.arm && state_ff == ST_TWO && sel2_ff[3:1] == 3'h7 |=> state_ff == ST_TWO)
    else $error("reserved code moved sequencer");
  a_armed_sel_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_ff.arm ##1 ctrl_ff.arm |-> $stable(sel1_ff) && $stable(sel2_ff))
    else $error("selector changed while armed");
  a_ch2_only: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_ff.arm && state_ff == ST_ONE && sel1_ff == 4'h4 && !match[2] |=> state_ff == ST_ONE)
    else $error("non channel 2 match acted");
  a_ch3_state1: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_ff.arm && state_ff == ST_TWO && sel2_ff == 4'h3 && match[3] |=> state_ff == ST_ONE)
    else $error("channel 3 did not reach state1");
  a_any_state2: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_ff.arm && state_ff == ST_ONE && sel1_ff == 4'h0 && match != 4'h0 |=> state_ff == ST_TWO)
    else $error("any match did not reach state2");
  a_view_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && !rvalid_ff && s_axi_araddr[31:2] == ADDR_SHARED[29:0] && ctrl_ff.view == VIEW_STATE1
    |=> s_axi_rdata[3:0] == $past(sel1_ff))
    else $error("shared read showed wrong view");
endmodule : seq_next_state
`default_nettype wire

// ### match_source.sv
// comparator match-channel model driving the raw hit lines
`default_nettype none
module match_source (
  input wire logic aclk,
  output logic [3:0] comp_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  initial comp_hit = 4'h0;
  // single-cycle hit: a held level would chain through several states
  task automatic pulse(input logic [3:0] hits);
    comp_hit <= hits;
    @(posedge aclk);
    comp_hit <= 4'h0;
    // sync plus state update settle well inside this
    repeat (6) @(posedge aclk);
  endtask : pulse
endmodule : match_source
`default_nettype wire

// ### debug_sequencer_next_state_tb.sv
// self-checking bench for the sequencer next-state block
`default_nettype none
module debug_sequencer_next_state_tb
  import seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rdat;
  logic [3:0] wstrb = 4'h0, comp_hit, en_mask = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, final_reached;
  logic [1:0] bresp, rresp, rsp, map_sel = MAP_PLAIN;
  logic [4:0] seq_state;
  int bad_count = 0;
  int checks = 0;
  always #5 aclk = ~aclk;
  seq_next_state seq_next_state_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .comp_hit(comp_hit), .seq_state(seq_state),
    .final_reached(final_reached)
  );
  match_source match_source_i (.aclk(aclk), .comp_hit(comp_hit));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp
  task automatic limit(input int n);
    if (n >= 40) begin
      bad_count++;
      wrap_up();
    end
  endtask : limit
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    // tasks take register indices; the bus address is four times that
    awaddr <= {a[29:0], 2'h0};
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    rsp = bresp;
    limit(n);
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [31:0] a);
    int n;
    n = 0;
    araddr <= {a[29:0], 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 40);
    rready <= 1'b0;
    rdat = rdata;
    rsp = rresp;
    limit(n);
    @(posedge aclk);
  endtask : rd
  task automatic sel_chk(input logic [1:0] view, input logic [3:0] exp);
    wr(ADDR_CONTROL, {30'h0, view});
    cmp({30'h0, rsp}, {30'h0, RESP_OKAY}, "write response");
    rd(ADDR_SHARED);
    cmp(rdat, {28'h0, exp}, "selector");
    cmp({30'h0, rsp}, {30'h0, RESP_OKAY}, "read response");
  endtask : sel_chk
  task automatic reg_scn;
    cmp({27'h0, seq_state}, {27'h0, ST_IDLE}, "reset state");
    sel_chk(VIEW_STATE1, SEL_RESET);
    wr(ADDR_SHARED, 32'h0000_0005);
    wr(ADDR_CONTROL, {30'h0, VIEW_STATE2});
    wr(ADDR_SHARED, 32'h0000_000A);
    wr(ADDR_CONTROL, {30'h0, VIEW_FLAGS});
    wr(ADDR_SHARED, 32'h0000_000F);
    // armed: the write must be dropped
    wr(ADDR_CONTROL, 32'h0000_0080);
    wr(ADDR_SHARED, 32'h0000_000C);
    sel_chk(VIEW_STATE2, 4'hA);
    sel_chk(VIEW_STATE1, 4'h5);
    rd(32'h0000_0010);
    cmp({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped response");
    cmp(rdat, 32'h0, "unmapped data");
    wr(32'h0000_0010, 32'h0);
    cmp({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write response");
  endtask : reg_scn
  task automatic rst_scn;
    // second reset in mid-run: selectors must fall back to their reset code
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp({27'h0, seq_state}, {27'h0, ST_IDLE}, "state after reset");
    sel_chk(VIEW_STATE2, SEL_RESET);
    sel_chk(VIEW_STATE1, SEL_RESET);
  endtask : rst_scn
  task automatic seq(input logic two, input logic [3:0] code, input logic [3:0] hits, input seq_state_e exp);
    logic [3:0] flag_exp;
    flag_exp = (two ? 4'h1 : 4'h0) | (hits & en_mask & ((map_sel == MAP_PLAIN) ? 4'hF : 4'hD));
    wr(ADDR_CONTROL, {30'h0, VIEW_STATE1});
    wr(ADDR_SHARED, {28'h0, two ? 4'h0 : code});
    wr(ADDR_CONTROL, {30'h0, VIEW_STATE2});
    wr(ADDR_SHARED, {28'h0, code});
    wr(ADDR_COMPARATOR, {28'h0, en_mask});
    wr(ADDR_CONTROL, {24'h0, 1'b1, 3'h0, map_sel, VIEW_STATE2});
    if (two) match_source_i.pulse(4'h1);
    match_source_i.pulse(hits);
    cmp({27'h0, seq_state}, {27'h0, exp}, "next state");
    cmp({31'h0, final_reached}, {31'h0, exp == ST_FINAL}, "final flag");
    // arm stays set, so the view change does not clear the flags
    wr(ADDR_CONTROL, {24'h0, 1'b1, 3'h0, map_sel, VIEW_FLAGS});
    rd(ADDR_SHARED);
    cmp(rdat, {28'h0, flag_exp}, "match flags");
  endtask : seq
  task automatic idle_scn;
    wr(ADDR_CONTROL, 32'h0);
    match_source_i.pulse(4'hF);
    cmp({27'h0, seq_state}, {27'h0, ST_IDLE}, "disarmed state");
  endtask : idle_scn
  task automatic one_scn;
    seq(1'b0, 4'h0, 4'h8, ST_TWO);
    seq(1'b0, 4'h1, 4'h1, ST_THREE);
    seq(1'b0, 4'h2, 4'h2, ST_FINAL);
    seq(1'b0, 4'h3, 4'hB, ST_ONE);
    seq(1'b0, 4'h3, 4'h4, ST_TWO);
    seq(1'b0, 4'h4, 4'h4, ST_THREE);
    seq(1'b0, 4'h5, 4'h4, ST_FINAL);
    seq(1'b0, 4'h6, 4'h3, ST_TWO);
    seq(1'b0, 4'h6, 4'h2, ST_THREE);
    seq(1'b0, 4'h7, 4'h3, ST_FINAL);
    seq(1'b0, 4'h7, 4'h2, ST_THREE);
    seq(1'b0, 4'h8, 4'h5, ST_TWO);
    seq(1'b0, 4'h8, 4'h4, ST_THREE);
    seq(1'b0, 4'h9, 4'h5, ST_FINAL);
    seq(1'b0, 4'hA, 4'h2, ST_TWO);
    seq(1'b0, 4'hA, 4'h8, ST_THREE);
    seq(1'b0, 4'hB, 4'hA, ST_FINAL);
    seq(1'b0, 4'hC, 4'h8, ST_ONE);
    seq(1'b0, 4'hC, 4'h4, ST_TWO);
    seq(1'b0, 4'hD, 4'hF, ST_ONE);
    seq(1'b0, 4'hE, 4'hF, ST_ONE);
    seq(1'b0, 4'hF, 4'hF, ST_ONE);
  endtask : one_scn
  task automatic two_scn;
    seq(1'b1, 4'h0, 4'h8, ST_ONE);
    seq(1'b1, 4'h1, 4'h1, ST_THREE);
    seq(1'b1, 4'h2, 4'h2, ST_FINAL);
    seq(1'b1, 4'h3, 4'h7, ST_TWO);
    seq(1'b1, 4'h3, 4'h8, ST_ONE);
    seq(1'b1, 4'h4, 4'h8, ST_THREE);
    seq(1'b1, 4'h5, 4'h8, ST_FINAL);
    seq(1'b1, 4'h6, 4'h1, ST_ONE);
    seq(1'b1, 4'h6, 4'h2, ST_THREE);
    seq(1'b1, 4'h7, 4'h3, ST_FINAL);
    seq(1'b1, 4'h8, 4'h4, ST_THREE);
    seq(1'b1, 4'h9, 4'h5, ST_FINAL);
    seq(1'b1, 4'hA, 4'hA, ST_ONE);
    seq(1'b1, 4'hB, 4'hA, ST_FINAL);
    seq(1'b1, 4'hC, 4'hC, ST_FINAL);
    seq(1'b1, 4'hD, 4'h4, ST_TWO);
    seq(1'b1, 4'hD, 4'h2, ST_FINAL);
    seq(1'b1, 4'hE, 4'hF, ST_TWO);
    seq(1'b1, 4'hF, 4'hF, ST_TWO);
  endtask : two_scn
  task automatic gate_scn;
    en_mask = 4'h1;
    seq(1'b0, 4'h0, 4'h8, ST_ONE);
    en_mask = 4'hF;
    map_sel = 2'h1;
    seq(1'b0, 4'h0, 4'h2, ST_ONE);
    map_sel = MAP_PLAIN;
  endtask : gate_scn
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reg_scn();
    idle_scn();
    one_scn();
    rst_scn();
    two_scn();
    gate_scn();
    wrap_up();
  end
endmodule : debug_sequencer_next_state_tb
`default_nettype wire
